// File: csp_map.vh
// Purpose: constants for the configuration-space local access port
// Assumes: 32-bit word registers, 12-bit byte address, word index = addr[11:2]
// Notes: reset values and writable masks are modelled for a small register set
`ifndef CSP_MAP_VH
`define CSP_MAP_VH
`define CSP_AW 12
`define CSP_DW 32
`define CSP_IW 10
`define CSP_IDX_LSB 2
`define CSP_IDX_MSB 11
`define CSP_DEPTH 1024
`define CSP_ZERO32 32'h00000000
`define CSP_ONES32 32'hFFFFFFFF
// modelled register words (word index)
`define CSP_NREG 8
`define CSP_IDX_W 3
`define CSP_ST_IDLE 2'h0
`define CSP_ST_WAIT 2'h1
`define CSP_ST_ACK 2'h2
`define CSP_OP_RD 1'b0
`define CSP_OP_WR 1'b1
`endif

// File: csp_cfg_regs.v
// Purpose: configuration-space word store shared by link requests and the local port
// Assumes: one access per cycle, chosen by the caller
// Notes: writable bits follow a per-word mask so both requesters see the same attributes
`include "csp_map.vh"
module csp_cfg_regs #(
  parameter NREG = `CSP_NREG,
  parameter IDXW = `CSP_IDX_W,
  parameter [NREG*32-1:0] WMASK = {NREG{`CSP_ONES32}},
  parameter [NREG*32-1:0] RSTVAL = {NREG{`CSP_ZERO32}}
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // single access port
  input wire acc_en_i,
  input wire acc_wr_i,
  input wire [`CSP_IW-1:0] acc_idx_i,
  input wire [`CSP_DW-1:0] acc_wdata_i,
  output wire [`CSP_DW-1:0] acc_rdata_o
);
  reg [`CSP_DW-1:0] mem_ff [0:NREG-1];
  wire hit;
  assign hit = (acc_idx_i < NREG);
  // unmodelled words read as zero
  assign acc_rdata_o = hit ? mem_ff[acc_idx_i[IDXW-1:0]] : `CSP_ZERO32;
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_word
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mem_ff[g] <= RSTVAL[g*`CSP_DW +: `CSP_DW];
        end else if (acc_en_i && acc_wr_i && hit && acc_idx_i[IDXW-1:0] == g) begin
          // read-only bits keep their value
          mem_ff[g] <= (mem_ff[g] & ~WMASK[g*`CSP_DW +: `CSP_DW]) |
                       (acc_wdata_i & WMASK[g*`CSP_DW +: `CSP_DW]);
        end
      end
    end
  endgenerate
endmodule // csp_cfg_regs

// File: csp_local_port.v
// Contract
// - port runs on the application clock, up to 250 MHz.
// - port address uses the configuration-space address map.
// - each read or write moves exactly one 32-bit word.
// - bit attributes are identical for port and link accesses.
// - a coinciding link configuration access wins over the port.
// - port writes wait until no link access is pending.
// - acknowledge returned once the held operation has executed.
// - port reads also wait until no link access is pending.
// - only local read and local write, request/acknowledge timing.
// - 12-bit address, two low bits ignored.
// - one acknowledge marks write done or read data valid.
// - writes change writable bits only; read-only bits remain.
//
// Purpose: local management port into the configuration-space registers
// Assumes: link-side requests arrive on the same clock from internal logic
// Notes: link requests are served the cycle they appear; port waits behind them
`include "csp_map.vh"
module csp_local_port #(
  parameter NREG = `CSP_NREG,
  parameter [NREG*32-1:0] WMASK = {NREG{`CSP_ONES32}},
  parameter [NREG*32-1:0] RSTVAL = {NREG{`CSP_ZERO32}}
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // local port
  input wire port_rd_i,
  input wire port_wr_i,
  input wire [`CSP_AW-1:0] port_addr_i,
  input wire [`CSP_DW-1:0] port_wdata_i,
  output wire [`CSP_DW-1:0] port_rdata_o,
  output wire port_ack_o,
  // link-side configuration requests
  input wire link_req_i,
  input wire link_wr_i,
  input wire [`CSP_AW-1:0] link_addr_i,
  input wire [`CSP_DW-1:0] link_wdata_i,
  output wire [`CSP_DW-1:0] link_rdata_o,
  output wire link_ack_o
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_s1_ff;
  reg rst_s2_ff;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n;
  assign rst_n = rst_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // word index shared by both requesters
  function [`CSP_IW-1:0] word_idx;
    input [`CSP_AW-1:0] a;
    begin
      word_idx = a[`CSP_IDX_MSB:`CSP_IDX_LSB];
    end
  endfunction

  // a strobe of either kind starts an operation
  function strobe_seen;
    input rd;
    input wr;
    begin
      strobe_seen = rd | wr;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // held port request
  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg op_ff;
  reg [`CSP_IW-1:0] idx_ff;
  reg [`CSP_DW-1:0] wdata_ff;
  reg [`CSP_DW-1:0] rdata_ff;
  reg ack_ff;
  reg lack_ff;
  reg [`CSP_DW-1:0] lrdata_ff;

  // link wins any cycle it requests
  wire port_go;
  assign port_go = (st_ff == `CSP_ST_WAIT) && !link_req_i;

  wire acc_en;
  wire acc_wr;
  wire [`CSP_IW-1:0] acc_idx;
  wire [`CSP_DW-1:0] acc_wdata;
  wire [`CSP_DW-1:0] acc_rdata;
  assign acc_en = link_req_i | port_go;
  assign acc_wr = link_req_i ? link_wr_i : (op_ff == `CSP_OP_WR);
  assign acc_idx = link_req_i ? word_idx(link_addr_i) : idx_ff;
  assign acc_wdata = link_req_i ? link_wdata_i : wdata_ff;

  // single store keeps attributes identical for both requesters
  csp_cfg_regs #(
    .NREG(NREG),
    .IDXW(`CSP_IDX_W),
    .WMASK(WMASK),
    .RSTVAL(RSTVAL)
  ) u_regs (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .acc_en_i(acc_en),
    .acc_wr_i(acc_wr),
    .acc_idx_i(acc_idx),
    .acc_wdata_i(acc_wdata),
    .acc_rdata_o(acc_rdata)
  );

  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      `CSP_ST_IDLE: begin
        if (strobe_seen(port_rd_i, port_wr_i)) begin
          nxt_st = `CSP_ST_WAIT;
        end
      end
      `CSP_ST_WAIT: begin
        if (port_go) begin
          nxt_st = `CSP_ST_ACK;
        end
      end
      `CSP_ST_ACK: begin
        nxt_st = `CSP_ST_IDLE;
      end
      default: begin
        nxt_st = `CSP_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values of the held request and of both answers
  reg nxt_op;
  reg [`CSP_IW-1:0] nxt_idx;
  reg [`CSP_DW-1:0] nxt_wdata;
  reg nxt_ack;
  reg [`CSP_DW-1:0] nxt_rdata;
  reg nxt_lack;
  reg [`CSP_DW-1:0] nxt_lrdata;

  // capture the request so later input changes cannot disturb it
  always @* begin
    nxt_op = op_ff;
    nxt_idx = idx_ff;
    nxt_wdata = wdata_ff;
    if (st_ff == `CSP_ST_IDLE && strobe_seen(port_rd_i, port_wr_i)) begin
      nxt_op = port_wr_i ? `CSP_OP_WR : `CSP_OP_RD;
      nxt_idx = word_idx(port_addr_i);
      nxt_wdata = port_wdata_i;
    end
  end

  // a write leaves the last read word in place on the data output
  always @* begin
    nxt_ack = port_go;
    nxt_rdata = rdata_ff;
    if (port_go && op_ff == `CSP_OP_RD) begin
      nxt_rdata = acc_rdata;
    end
  end

  // link answers never wait, so they need no state of their own
  always @* begin
    nxt_lack = link_req_i;
    nxt_lrdata = lrdata_ff;
    if (link_req_i && !link_wr_i) begin
      nxt_lrdata = acc_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, all on the application clock
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= `CSP_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      op_ff <= `CSP_OP_RD;
      idx_ff <= {`CSP_IW{1'b0}};
      wdata_ff <= `CSP_ZERO32;
    end else begin
      op_ff <= nxt_op;
      idx_ff <= nxt_idx;
      wdata_ff <= nxt_wdata;
    end
  end

  // outputs come straight from these flops
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= `CSP_ZERO32;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lack_ff <= 1'b0;
      lrdata_ff <= `CSP_ZERO32;
    end else begin
      lack_ff <= nxt_lack;
      lrdata_ff <= nxt_lrdata;
    end
  end

  assign port_ack_o = ack_ff;
  assign port_rdata_o = rdata_ff;
  assign link_ack_o = lack_ff;
  assign link_rdata_o = lrdata_ff;
endmodule // csp_local_port

// File: csp_port_sva.sv
// Purpose: timing checks on the local port and the link side
// Assumes: one clock, bench keeps one port operation in flight
// Notes: bsy_ff marks a port operation taken and not yet acknowledged
module csp_port_sva (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // port and link
  input wire port_rd_i,
  input wire port_wr_i,
  input wire [31:0] port_rdata_o,
  input wire port_ack_o,
  input wire link_req_i,
  input wire link_ack_o
);
  reg bsy_ff;
  wire take = (port_rd_i | port_wr_i) & ~bsy_ff;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) bsy_ff <= 1'b0;
    else if (port_ack_o) bsy_ff <= 1'b0;
    else if (port_rd_i | port_wr_i) bsy_ff <= 1'b1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_link_ack_next: assert property (link_req_i |=> link_ack_o)
    else $error("link ack late");
  a_link_ack_cause: assert property (link_ack_o |-> $past(link_req_i))
    else $error("link ack without request");
  a_port_ack_due: assert property (take ##1 !link_req_i |=> port_ack_o)
    else $error("port ack late");
  a_port_yields: assert property (take ##1 link_req_i |=> !port_ack_o)
    else $error("port ran beside link access");
  a_port_resumes: assert property (take ##1 link_req_i [*3] ##1 !link_req_i |=> port_ack_o)
    else $error("port not resumed");
  a_ack_owned: assert property (port_ack_o |-> bsy_ff)
    else $error("ack with nothing pending");
  a_ack_single: assert property (port_ack_o |=> !port_ack_o)
    else $error("ack longer than one cycle");
  a_rdata_held: assert property ($changed(port_rdata_o) |-> port_ack_o)
    else $error("read data moved without ack");
endmodule // csp_port_sva
bind csp_local_port csp_port_sva u_csp_port_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .port_rd_i(port_rd_i), .port_wr_i(port_wr_i), .port_rdata_o(port_rdata_o),
  .port_ack_o(port_ack_o), .link_req_i(link_req_i), .link_ack_o(link_ack_o));

// File: csp_app_model.sv
// Purpose: application logic that issues local port reads and writes
// Assumes: ack and read data change at the rising edge
// Notes: address and data are inverted once released so stale values never look valid
module csp_app_model (
  input wire clk_i,
  input wire [31:0] rdata_i,
  input wire ack_i,
  output logic rd_o = 1'b0,
  output logic wr_o = 1'b0,
  output logic [11:0] addr_o = 12'h000,
  output logic [31:0] wdata_o = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output int n);
    // ack raised at a rising edge is sampled at the next falling edge
    n = 1;
    @(negedge clk_i);
    rd_o <= ~w;
    wr_o <= w;
    addr_o <= a;
    wdata_o <= d;
    @(negedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    while (ack_i !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    q = rdata_i;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule // csp_app_model

// File: csp_local_port_test.sv
// Purpose: self-checking bench for the local port
// Assumes: word 1 has only its low half writable
// Notes: link traffic is driven here, port traffic by the application model
module csp_local_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_n_i = 1'b0, link_req_i = 1'b0, link_wr_i = 1'b0;
  logic [11:0] link_addr_i = 12'h000;
  logic [31:0] link_wdata_i = 32'h0, q;
  wire rd, wr, ack, link_ack_o;
  wire [11:0] addr;
  wire [31:0] wdata, rdata, link_rdata_o;
  int bad_count = 0, n_tests = 0, n;
  always #2.5 clk_i = ~clk_i;
  csp_local_port #(.WMASK({{6{32'hFFFFFFFF}}, 32'h0000FFFF, 32'hFFFFFFFF})) u_csp_local_port (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .port_rd_i(rd), .port_wr_i(wr), .port_addr_i(addr),
    .port_wdata_i(wdata), .port_rdata_o(rdata), .port_ack_o(ack), .link_req_i(link_req_i),
    .link_wr_i(link_wr_i), .link_addr_i(link_addr_i), .link_wdata_i(link_wdata_i),
    .link_rdata_o(link_rdata_o), .link_ack_o(link_ack_o));
  csp_app_model u_csp_app_model (.clk_i(clk_i), .rdata_i(rdata), .ack_i(ack), .rd_o(rd),
    .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
  task chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task link(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_i);
    {link_req_i, link_wr_i, link_addr_i, link_wdata_i} <= {1'b1, w, a, d};
    @(negedge clk_i);
    {link_req_i, link_addr_i, link_wdata_i} <= {1'b0, ~a, ~d};
    @(negedge clk_i);
  endtask
  task t_write_read;
    u_csp_app_model.access(1'b1, 12'h000, 32'h12345678, q, n);
    chk(n == 2, "write latency");
    u_csp_app_model.access(1'b0, 12'h003, 32'h0, q, n);
    chk(q === 32'h12345678, "word 0 readback");
    chk(n == 2, "read latency");
    u_csp_app_model.access(1'b1, 12'h004, 32'hFFFFFFFF, q, n);
    u_csp_app_model.access(1'b0, 12'h004, 32'h0, q, n);
    chk(q === 32'h0000FFFF, "read-only half changed");
  endtask
  task t_link_cross;
    link(1'b0, 12'h004, 32'h0);
    chk(link_rdata_o === 32'h0000FFFF, "link view differs");
    link(1'b1, 12'h008, 32'hA5A55A5A);
    u_csp_app_model.access(1'b0, 12'h008, 32'h0, q, n);
    chk(q === 32'hA5A55A5A, "port view of link write");
  endtask
  task t_priority;
    fork
      u_csp_app_model.access(1'b0, 12'h00C, 32'h0, q, n);
      begin
        repeat (2) @(negedge clk_i);
        {link_req_i, link_wr_i, link_addr_i, link_wdata_i} <= {2'h3, 12'h00C, 32'h5A5A0F0F};
        repeat (3) @(negedge clk_i);
        link_req_i <= 1'b0;
      end
    join
    chk(n == 5, "port did not wait for link");
    chk(q === 32'h5A5A0F0F, "read before link writes");
  endtask
  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_write_read();
    t_link_cross();
    t_priority();
    report_and_stop();
  end
  initial begin
    #5000;
    $display("ERROR %0t watchdog expired", $time);
    bad_count++;
    report_and_stop();
  end
endmodule // csp_local_port_test
